// ### core/psr_regs.vh
/*
 * Constants for the pressure readout block: register reset values,
 * field positions, record layout and timing counts.
 * Assumes it is included by bare name from core/ design files only.
 */
`ifndef PSR_REGS_VH
`define PSR_REGS_VH

// Register reset values
`define PSR_MODE_RESET 8'h3f
`define PSR_RATE_RESET 8'h01
// Range and filter fields of the mode reset value
`define PSR_MODE_FIELDS_RESET 6'h3f

// Range and filter field positions in the mode control register
`define PSR_RANGE_LSB 0
`define PSR_RANGE_MSB 2
`define PSR_FILT_LSB 3
`define PSR_FILT_MSB 5

// Record layout, zero-based byte indices within one transfer
`define PSR_IDX_MODE 5'h00
`define PSR_IDX_RATE 5'h01
`define PSR_IDX_PRES 5'h01
`define PSR_IDX_TEMP 5'h04
`define PSR_IDX_MODEL 5'h06
`define PSR_IDX_SERIAL 5'h0e
`define PSR_IDX_BUILD 5'h12
`define PSR_REC_BYTES 5'h18

// Fill value for bytes past the record end
`define PSR_FILL_BYTE 8'h00

// Pressure span scaling: 90 percent of span, 5 percent offset
`define PSR_SCALE_NUM 25'h0e66666
`define PSR_SCALE_OFS 24'h0ccccd

// Clock and timing figures
`define PSR_CLK_HZ 100000000
`define PSR_UPDATE_HZ 1090
`define PSR_UPDATE_CYCLES (`PSR_CLK_HZ / `PSR_UPDATE_HZ)
`define PSR_SETTLE_MS 55
`define PSR_SETTLE_CYCLES (`PSR_CLK_HZ / 1000 * `PSR_SETTLE_MS)
`define PSR_DETECT_CYCLES 1000
`define PSR_FLAG_NS 1000
`define PSR_FLAG_CYCLES (`PSR_FLAG_NS * (`PSR_CLK_HZ / 1000000) / 1000)

// Sample buffer shape
`define PSR_FIFO_DEPTH 16
`define PSR_FIFO_AW 4

`endif

// ### core/psr_fifo.v
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and an asynchronous active-high reset; AW must be
 * log2 of DEPTH.
 */
module psr_fifo #(
    parameter WIDTH = 48,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Fill side
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    // Drain side
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData
);

    // Storage words
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    // Pointers and fill count
    reg [AW-1:0] wrPtr_reg;
    reg [AW-1:0] rdPtr_reg;
    reg [AW:0] count_reg;
    wire doPush;
    wire doPop;

    // Honest full and empty
    assign inReady = (count_reg != DEPTH[AW:0]);
    assign outValid = (count_reg != {(AW+1){1'b0}});
    assign outData = mem[rdPtr_reg];
    assign doPush = inValid && inReady;
    assign doPop = outValid && outReady;

    // Write into storage
    always @(posedge core_clk)
    begin
        if (doPush)
        begin
            mem[wrPtr_reg] <= inData;
        end
    end

    // Pointer and count update
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            wrPtr_reg <= {AW{1'b0}};
            rdPtr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end
        else
        begin
            if (doPush)
            begin
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (doPop)
            begin
                rdPtr_reg <= rdPtr_reg + 1'b1;
            end
            // Simultaneous push and pop leaves count unchanged
            if (doPush && !doPop)
            begin
                count_reg <= count_reg + 1'b1;
            end
            else if (doPop && !doPush)
            begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule

// ### core/psr_readout.v
/*
 * Pressure sensor readout: SPI slave (mode 1) returning a 24-byte record,
 * mode/rate control registers, update-rate divider driving the new
 * sample flag, sample buffer, pressure span scaling, settling timer and
 * interface detection.
 * Assumes the link pins are asynchronous to core_clk and toggle much
 * slower than it; the sensor core supplies raw samples by valid/ready.
 */
`include "psr_regs.vh"

// How it works
// - Record: mode, pressure, temperature, model, serial, build
// - Temperature sent as signed 8.8 Celsius
// - Model is eight ASCII bytes, zero ended
// - Four-byte serial unique per part
// - Build is six ASCII bytes, zero ended
// - Only first two received bytes load registers
// - Bytes after the 24th are undefined
// - Mode resets 0x3F: range, filter, reserved
// - New mode applies from the end of the next frame
// - Rate value reloads update divider for flag
// - Rate resets 0x01; zero acts as one
// - Settings written during settling are kept
// - Pressure 24-bit unsigned, MSB first
// - Range fills 90% of span, 5% margins
// - SPI idle low clock, sample falling edge
// - Every byte travels MSB first
// - Rising edge on flag per new reading
// - After detect delay, select high means SPI
module psr_readout #(
    parameter UPDATE_CYCLES = `PSR_UPDATE_CYCLES,
    parameter SETTLE_CYCLES = `PSR_SETTLE_CYCLES,
    parameter DETECT_CYCLES = `PSR_DETECT_CYCLES,
    parameter [63:0] MODEL_STR = 64'h5053_5230_3031_0000,
    parameter [31:0] SERIAL_NUM = 32'h1234_5678,
    parameter [47:0] BUILD_STR = 48'h3030_3031_4100
) (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Link pins
    input wire frameSelectLowIn,
    input wire sckIn,
    input wire mosiIn,
    output reg misoOut,
    output wire misoOe,
    output reg newSampleFlag,
    // Sensor core samples
    input wire sampleValid,
    output wire sampleReady,
    input wire [23:0] sampleRaw,
    input wire [15:0] sampleTemp,
    output wire [2:0] rangeSelect,
    output wire [2:0] filterSelect,
    // Status
    output reg ifaceDetected,
    output reg ifaceIsSpi,
    output reg filterSettled
);

    // Select one record byte by index
    function [7:0] recordByte;
        input [4:0] idx;
        input [47:0] smp;
        begin
            // sampled fields first, then fixed strings
            if (idx < `PSR_IDX_MODEL)
                recordByte = smp[8*(5 - idx) +: 8];
            else if (idx >= `PSR_REC_BYTES)
                recordByte = `PSR_FILL_BYTE;
            else if (idx >= `PSR_IDX_BUILD)
                recordByte = BUILD_STR[8*(`PSR_IDX_BUILD + 5 - idx) +: 8];
            else if (idx >= `PSR_IDX_SERIAL)
                recordByte = SERIAL_NUM[8*(`PSR_IDX_SERIAL + 3 - idx) +: 8];
            else
                recordByte = MODEL_STR[8*(`PSR_IDX_MODEL + 7 - idx) +: 8];
        end
    endfunction

    // Pin synchronisers, stage one and two, plus edge history
    reg [2:0] ssSync_reg;
    reg [2:0] sckSync_reg;
    reg [1:0] mosiSync_reg;
    wire ssLow;
    wire sckRise, sckFall;
    wire frameStart;
    // Control registers
    reg [7:0] modeCtl_reg;
    reg [7:0] rateCtl_reg;
    reg [5:0] modePending_reg;
    reg [5:0] modeActive_reg;
    // SPI shifter state
    reg [4:0] byteIdx_reg;
    reg [2:0] bitCnt_reg;
    reg [7:0] rxShift_reg;
    reg [7:0] txShift_reg;
    reg inFrame_reg;
    // Sample snapshot and current result
    reg [47:0] snapshot_reg;
    reg [47:0] result_reg;
    // Update tick divider and rate divider
    reg [16:0] updCnt_reg;
    reg updTick;
    reg [7:0] divCnt_reg;
    reg [7:0] flagCnt_reg;
    localparam integer FLAG_CYCLES = `PSR_FLAG_CYCLES; // Flag high time in cycles
    // Start-up timers
    reg [22:0] settleCnt_reg;
    reg [15:0] detectCnt_reg;
    // Scaled pressure path
    wire [48:0] scaleProd;
    wire [23:0] scaledPres;
    wire [47:0] fifoIn, fifoOut;
    wire fifoOutValid;
    wire [7:0] rateEff;
    wire [7:0] txByte; // Byte whose top bit goes out next

    assign ssLow = !ssSync_reg[1];
    assign sckRise = sckSync_reg[1] && !sckSync_reg[2];
    assign sckFall = !sckSync_reg[1] && sckSync_reg[2];
    assign frameStart = !ssSync_reg[1] && ssSync_reg[2];
    assign misoOe = ifaceIsSpi && ssLow;
    assign rangeSelect = modeActive_reg[`PSR_RANGE_MSB:`PSR_RANGE_LSB];
    assign filterSelect = modeActive_reg[`PSR_FILT_MSB:`PSR_FILT_LSB];

    // map raw span onto 90 percent with 5 percent floor
    assign scaleProd = sampleRaw * `PSR_SCALE_NUM;
    assign scaledPres = scaleProd[47:24] + `PSR_SCALE_OFS;
    // tag each sample with mode in force; temp passes as 8.8
    assign fifoIn = {2'b00, modeActive_reg, scaledPres, sampleTemp};
    // zero rate acts as divisor one
    assign rateEff = (rateCtl_reg == 8'h00) ? 8'h01 : rateCtl_reg;
    // fresh record byte at each boundary, MSB out first
    assign txByte = (bitCnt_reg == 3'h0) ? recordByte(byteIdx_reg, snapshot_reg) : txShift_reg;

    // Sample buffer between sensor core and update tick
    psr_fifo #(
        .WIDTH(48),
        .DEPTH(`PSR_FIFO_DEPTH),
        .AW(`PSR_FIFO_AW)
    ) sampleFifo (
        .core_clk(core_clk),
        .rst(rst),
        .inValid(sampleValid),
        .inReady(sampleReady),
        .inData(fifoIn),
        .outValid(fifoOutValid),
        .outReady(updTick),
        .outData(fifoOut)
    );

    // Two-flop synchronisers for link pins
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ssSync_reg <= 3'h7;
            sckSync_reg <= 3'h0;
            mosiSync_reg <= 2'h0;
        end
        else
        begin
            ssSync_reg <= {ssSync_reg[1:0], frameSelectLowIn};
            sckSync_reg <= {sckSync_reg[1:0], sckIn};
            mosiSync_reg <= {mosiSync_reg[0], mosiIn};
        end
    end

    // Interface detection and settling timer
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            detectCnt_reg <= 16'h0000;
            ifaceDetected <= 1'b0;
            ifaceIsSpi <= 1'b0;
            settleCnt_reg <= 23'h000000;
            filterSettled <= 1'b0;
        end
        else
        begin
            // sample select level once the detect delay ends
            if (!ifaceDetected)
            begin
                if (detectCnt_reg == DETECT_CYCLES[15:0] - 16'h0001)
                begin
                    ifaceDetected <= 1'b1;
                    ifaceIsSpi <= ssSync_reg[1];
                end
                else
                    detectCnt_reg <= detectCnt_reg + 16'h0001;
            end
            if (!filterSettled)
            begin
                if (settleCnt_reg == SETTLE_CYCLES[22:0] - 23'h000001)
                    filterSettled <= 1'b1;
                else
                    settleCnt_reg <= settleCnt_reg + 23'h000001;
            end
        end
    end

    // Internal update tick and buffer drain into the result
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            updCnt_reg <= 17'h00000;
            updTick <= 1'b0;
            result_reg <= {2'b00, `PSR_MODE_FIELDS_RESET, 40'h0000000000};
        end
        else
        begin
            updTick <= 1'b0;
            if (updCnt_reg == UPDATE_CYCLES[16:0] - 17'h00001)
            begin
                updCnt_reg <= 17'h00000;
                updTick <= 1'b1;
            end
            else
                updCnt_reg <= updCnt_reg + 17'h00001;
            // Take the buffered sample in the tick that pops it
            if (updTick && fifoOutValid)
                result_reg <= fifoOut;
        end
    end

    // Rate divider and new sample flag pulse
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            divCnt_reg <= `PSR_RATE_RESET;
            flagCnt_reg <= 8'h00;
            newSampleFlag <= 1'b0;
        end
        else
        begin
            // count down per update, fire, reload
            if (updTick)
            begin
                if (divCnt_reg <= 8'h01)
                begin
                    divCnt_reg <= rateEff;
                    // raise the flag for a fixed width
                    newSampleFlag <= 1'b1;
                    flagCnt_reg <= FLAG_CYCLES[7:0];
                end
                else
                    divCnt_reg <= divCnt_reg - 8'h01;
            end
            else if (flagCnt_reg != 8'h00)
            begin
                flagCnt_reg <= flagCnt_reg - 8'h01;
                if (flagCnt_reg == 8'h01)
                    newSampleFlag <= 1'b0;
            end
        end
    end

    // SPI slave shifter and control register loading
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            modeCtl_reg <= `PSR_MODE_RESET;
            rateCtl_reg <= `PSR_RATE_RESET;
            modePending_reg <= `PSR_MODE_FIELDS_RESET;
            modeActive_reg <= `PSR_MODE_FIELDS_RESET;
            byteIdx_reg <= 5'h00;
            bitCnt_reg <= 3'h0;
            rxShift_reg <= 8'h00;
            txShift_reg <= 8'h00;
            inFrame_reg <= 1'b0;
            snapshot_reg <= 48'h000000000000;
            misoOut <= 1'b0;
        end
        else if (!ifaceIsSpi)
            inFrame_reg <= 1'b0;
        else if (frameStart)
        begin
            // Freeze one record for the whole transfer
            inFrame_reg <= 1'b1;
            snapshot_reg <= result_reg;
            byteIdx_reg <= 5'h00;
            bitCnt_reg <= 3'h0;
        end
        else if (inFrame_reg && !ssLow)
        begin
            // frame end: pending moves to active, new mode moves to pending
            inFrame_reg <= 1'b0;
            modeActive_reg <= modePending_reg;
            modePending_reg <= modeCtl_reg[5:0];
        end
        else if (inFrame_reg)
        begin
            // drive on rising edge, CPOL 0 CPHA 1
            if (sckRise)
            begin
                txShift_reg <= {txByte[6:0], 1'b0};
                misoOut <= txByte[7];
            end
            // sample host data on falling edge
            if (sckFall)
            begin
                rxShift_reg <= {rxShift_reg[6:0], mosiSync_reg[1]};
                bitCnt_reg <= bitCnt_reg + 3'h1;
                if (bitCnt_reg == 3'h7)
                begin
                    // only first two bytes reach the registers
                    if (byteIdx_reg == `PSR_IDX_MODE)
                        modeCtl_reg <= {2'b00, rxShift_reg[4:0], mosiSync_reg[1]};
                    else if (byteIdx_reg == `PSR_IDX_RATE)
                        rateCtl_reg <= {rxShift_reg[6:0], mosiSync_reg[1]};
                    // index saturates past the record, fill returned
                    if (byteIdx_reg != 5'h1f)
                        byteIdx_reg <= byteIdx_reg + 5'h01;
                end
            end
        end
    end

endmodule

// ### sim/psr_readout_chk.sv
/* Port checker for psr_readout: flag pulse, link enable, detection,
   settling and mode update timing.
   Assumes it is bound onto psr_readout with the same short counts. */
module psr_readout_chk #(
    parameter SETTLE_CYCLES = 1000,
    parameter DETECT_CYCLES = 20
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Link pins
    input wire logic frameSelectLowIn,
    input wire logic misoOe,
    input wire logic newSampleFlag,
    // Mode and status
    input wire logic [2:0] rangeSelect,
    input wire logic [2:0] filterSelect,
    input wire logic ifaceDetected,
    input wire logic ifaceIsSpi,
    input wire logic filterSettled
);
    timeunit 1ns;
    timeprecision 100ps;
    // Cycles since reset, saturating
    logic [31:0] cyc;
    // High time of the current flag pulse
    logic [7:0] flagLen;

    // Helper counters
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            cyc <= 32'h0;
            flagLen <= 8'h0;
        end
        else
        begin
            cyc <= (&cyc) ? cyc : cyc + 32'h1;
            flagLen <= newSampleFlag ? flagLen + 8'h1 : 8'h0;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    a_flag_len: assert property (
        $fell(newSampleFlag) |-> flagLen == 8'h64)
        else $error("flag pulse not 100 cycles");
    a_oe_idle: assert property (
        frameSelectLowIn [*4] |-> !misoOe)
        else $error("data driven while deselected");
    a_oe_spi: assert property (
        misoOe |-> ifaceIsSpi && ifaceDetected)
        else $error("data driven without link select");
    a_iface_hold: assert property (
        ifaceDetected |=> ifaceDetected && $stable(ifaceIsSpi))
        else $error("link choice changed");
    a_detect_time: assert property (
        $rose(ifaceDetected) |-> cyc >= DETECT_CYCLES - 1 && cyc <= DETECT_CYCLES + 3)
        else $error("detection at wrong time");
    a_settle_time: assert property (
        $rose(filterSettled) |-> cyc >= SETTLE_CYCLES - 1 && cyc <= SETTLE_CYCLES + 3)
        else $error("settling at wrong time");
    a_mode_reset: assert property (
        !ifaceDetected |-> rangeSelect == 3'h7 && filterSelect == 3'h7)
        else $error("mode not at reset value");
    a_mode_at_end: assert property (
        $changed({rangeSelect, filterSelect}) |-> frameSelectLowIn && !$past(frameSelectLowIn, 8))
        else $error("mode changed outside frame end");
endmodule

bind psr_readout psr_readout_chk #(
    .SETTLE_CYCLES(SETTLE_CYCLES),
    .DETECT_CYCLES(DETECT_CYCLES)
) i_chk (
    .core_clk(core_clk), .rst(rst), .frameSelectLowIn(frameSelectLowIn),
    .misoOe(misoOe), .newSampleFlag(newSampleFlag), .rangeSelect(rangeSelect),
    .filterSelect(filterSelect), .ifaceDetected(ifaceDetected),
    .ifaceIsSpi(ifaceIsSpi), .filterSettled(filterSettled)
);

// ### sim/psr_host_model.sv
/* Host master model driving the readout link in framed transfers.
   Assumes an 80 ns link clock and idle-low clock polarity. */
module psr_host_model (
    // Link pins driven by the host
    output logic frameSelectLowIn,
    output logic sckIn,
    output logic mosiIn,
    // Device reply
    input wire logic misoOut,
    input wire logic misoOe
);
    timeunit 1ns;
    timeprecision 100ps;

    // Bytes caught from the device in the last frame
    logic [7:0] rxBuf [0:31];

    // Idle: deselected, clock still
    initial
    begin
        frameSelectLowIn = 1'b1;
        sckIn = 1'b0;
        mosiIn = 1'b1;
    end

    // SPI only: acknowledge-driven I2C reads are not modelled
    // One transfer: mode and rate first, filler after
    task automatic frame(input int nBytes, input logic [7:0] modeB, input logic [7:0] rateB);
        logic [7:0] tx;
        frameSelectLowIn = 1'b0;
        #100;
        for (int b = 0; b < nBytes; b++)
        begin
            tx = (b == 0) ? modeB : (b == 1) ? rateB : 8'ha5;
            for (int i = 7; i >= 0; i--)
            begin
                // shift on rise, sample on fall
                sckIn = 1'b1;
                mosiIn = tx[i];
                #40;
                sckIn = 1'b0;
                rxBuf[b][i] = misoOe ? misoOut : 1'bx;
                #40;
            end
        end
        #100;
        // select held for the whole read
        frameSelectLowIn = 1'b1;
        // Released line shows the inverse of its last bit
        mosiIn = ~mosiIn;
        #100;
    endtask
endmodule

// ### sim/testbench.sv
/* Self-checking bench for psr_readout: host model on the link,
   bench drives the sample side. Assumes shortened counts. */
`define CHECK_EQ(got, exp) \
    begin \
        nTests++; \
        if ((got) !== (exp)) \
        begin \
            numErrors++; \
            $display("BAD %0t got %h exp %h", $time, got, exp); \
        end \
    end

module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int UPD = 200;
    localparam [63:0] MODEL = 64'h4142_4358_3132_3300; // arbitrary text
    localparam [31:0] SERIAL = 32'h5a3c_9617; // arbitrary value
    localparam [47:0] BUILD = 48'h3031_3233_4200; // arbitrary text
    logic core_clk, rst, sampleValid;
    logic [23:0] sampleRaw;
    logic [15:0] sampleTemp;
    wire frameSelectLowIn, sckIn, mosiIn, misoOut, misoOe, newSampleFlag, sampleReady;
    wire [2:0] rangeSelect, filterSelect;
    wire ifaceDetected, ifaceIsSpi, filterSettled;
    int numErrors = 0;
    int nTests = 0;

    psr_readout #(.UPDATE_CYCLES(UPD), .SETTLE_CYCLES(1000), .DETECT_CYCLES(20),
        .MODEL_STR(MODEL), .SERIAL_NUM(SERIAL), .BUILD_STR(BUILD)) i_dut (
        .core_clk(core_clk), .rst(rst), .frameSelectLowIn(frameSelectLowIn),
        .sckIn(sckIn), .mosiIn(mosiIn), .misoOut(misoOut), .misoOe(misoOe),
        .newSampleFlag(newSampleFlag), .sampleValid(sampleValid),
        .sampleReady(sampleReady), .sampleRaw(sampleRaw), .sampleTemp(sampleTemp),
        .rangeSelect(rangeSelect), .filterSelect(filterSelect),
        .ifaceDetected(ifaceDetected), .ifaceIsSpi(ifaceIsSpi),
        .filterSettled(filterSettled));
    psr_host_model i_host (.frameSelectLowIn(frameSelectLowIn), .sckIn(sckIn),
        .mosiIn(mosiIn), .misoOut(misoOut), .misoOe(misoOe));

    // 100 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Counts and verdict, then stop
    task automatic giveVerdict();
        $display("Checks %0d, errors %0d", nTests, numErrors);
        if (numErrors == 0 && nTests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // A bounded wait ran out
    task automatic timeOut();
        numErrors++;
        $display("BAD %0t wait ran out", $time);
        giveVerdict();
    endtask

    // Wait for detection (0) or settling (1)
    task automatic waitLevel(input int sel);
        for (int k = 0; (sel ? filterSettled : ifaceDetected) !== 1'b1; k++)
        begin
            if (k > 2000)
                timeOut();
            @(posedge core_clk);
            #1;
        end
    endtask

    // Cycles up to the next flag rise
    task automatic flagRise(output int n);
        logic prev;
        n = 0;
        prev = 1'b1;
        while (!(newSampleFlag === 1'b1 && prev === 1'b0))
        begin
            prev = newSampleFlag;
            @(posedge core_clk);
            #1;
            n++;
            if (n > 2000)
                timeOut();
        end
    endtask

    // Offer one sample for one cycle
    task automatic pushSample(input logic [23:0] raw, input logic [15:0] tmp);
        sampleRaw = raw;
        sampleTemp = tmp;
        sampleValid = 1'b1;
        @(posedge core_clk);
        #1;
        sampleValid = 1'b0;
        // Let an edge pass before the next offer
        @(posedge core_clk);
        #1;
    endtask

    // Expected pressure code for a raw fraction
    function automatic logic [23:0] scaleP(input logic [23:0] r);
        logic [47:0] m;
        m = {24'h0, r} * 48'he66666;
        return m[47:24] + 24'h0ccccd;
    endfunction

    // Compare the first bytes of the last frame
    task automatic checkFrame(input int nb, input logic [7:0] md, input logic [23:0] raw,
        input logic [15:0] tmp);
        logic [191:0] rec;
        rec = {md, scaleP(raw), tmp, MODEL, SERIAL, BUILD};
        for (int i = 0; i < nb; i++)
            `CHECK_EQ(i_host.rxBuf[i], rec[191 - 8 * i -: 8])
    endtask

    // Reset values, link choice, default flag rate
    task automatic startupCheck();
        int n;
        `CHECK_EQ(rangeSelect, 3'h7)
        `CHECK_EQ(filterSelect, 3'h7)
        waitLevel(0);
        `CHECK_EQ(ifaceIsSpi, 1'b1)
        flagRise(n);
        flagRise(n);
        `CHECK_EQ(n, UPD)
    endtask

    // Short setup frame while still settling
    task automatic configEarly();
        `CHECK_EQ(filterSettled, 1'b0)
        i_host.frame(2, 8'hdd, 8'h00);
        `CHECK_EQ(rangeSelect, 3'h7)
        waitLevel(1);
    endtask

    // Full record, old mode echoed, new mode after it
    task automatic recordCheck();
        int n;
        pushSample(24'hffffff, 16'h1880);
        flagRise(n);
        i_host.frame(26, 8'hdd, 8'h00);
        checkFrame(24, 8'h3f, 24'hffffff, 16'h1880);
        `CHECK_EQ(rangeSelect, 3'h5)
        `CHECK_EQ(filterSelect, 3'h3)
    endtask

    // Zero rate acts as one, then a divisor of three
    task automatic rateCheck();
        int n;
        pushSample(24'h000000, 16'hff80);
        flagRise(n);
        flagRise(n);
        `CHECK_EQ(n, UPD)
        i_host.frame(3, 8'hdd, 8'h03);
        checkFrame(3, 8'h1d, 24'h000000, 16'hff80);
        flagRise(n);
        flagRise(n);
        flagRise(n);
        `CHECK_EQ(n, 3 * UPD)
    endtask

    // Fill the buffer until it refuses, then drain it
    task automatic fillDrain();
        int n;
        flagRise(n);
        for (int k = 0; k < 16; k++)
            pushSample({12'h000, k[3:0], 8'h00}, 16'h0000);
        `CHECK_EQ(sampleReady, 1'b0)
        pushSample(24'hffff00, 16'h0000);
        repeat (17 * UPD) @(posedge core_clk);
        #1;
        `CHECK_EQ(sampleReady, 1'b1)
        i_host.frame(6, 8'hdd, 8'h03);
        checkFrame(6, 8'h1d, 24'h000f00, 16'h0000);
    endtask

    // Main sequence
    initial
    begin
        rst = 1'b1;
        sampleValid = 1'b0;
        sampleRaw = 24'h0;
        sampleTemp = 16'h0;
        repeat (8) @(posedge core_clk);
        #1;
        rst = 1'b0;
        startupCheck();
        configEarly();
        recordCheck();
        rateCheck();
        fillDrain();
        giveVerdict();
    end
endmodule
